// ==== hw/chgirq_top.v ====
// Charger status, interrupt and protection logic.
// Assumes analog comparators give levels; they are synchronised here.
// How it works
// - Input good status high, pin low, when input valid, strong, detected.
// - Unmasked events give low interrupt pulses of 256 us; events during a pulse queue one more.
// - Interrupt on good input found, removed, or source type change.
// - Interrupt on entering current, voltage or thermal regulation.
// - Watchdog expiry interrupts; also once after power-up as ready.
// - Charge state change or battery temperature change interrupts.
// - Interrupt on input overvoltage, thermal shutdown, battery overvoltage, timer.
// - Status rising edge pulses interrupt and sets the flag.
// - Per-source mask suppresses that source's pulse.
// - Status shows live condition; flag latches the cause.
// - Reading flags clears them; only a new edge sets again.
// - Current-limit pin regulation counts only while pin enabled.
// - Input overvoltage stops switching, flags, resumes when cleared.
// - Weak input stops switching, drops input good, flags, retries.
// - System overvoltage stops the converter at once.
// - Load short stops switching, flags, interrupts, auto recovers.
// - Reverse overvoltage clears reverse enable, faults, interrupts.
// - Reverse output short clears reverse enable, faults, interrupts.
// - Thermal regulation halves timer, stops termination, interrupts.
// - Boost thermal shutdown stops converter, restarts after cooling.
// - Reverse thermal shutdown clears enable; host re-enables.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "chgirq_defines.vh"

module chgirq_top #(
    parameter PULSE_CYC = `CHGIRQ_PULSE_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Analog comparator levels
    input wire vin_above_uvlo,
    input wire vin_over_ov,
    input wire vin_poor,
    input wire src_detect_done,
    input wire [2:0] source_type_status,
    input wire icr_register_loop,
    input wire current_limit_pin_over,
    input wire vreg_loop,
    input wire tj_over_thermal_regulation_limit,
    input wire tj_over_shut,
    input wire tj_below_hys,
    input wire wdog_expired,
    input wire [2:0] charge_state,
    input wire [2:0] battery_temp_status,
    input wire bat_over_ov,
    input wire safety_tmr_expired,
    input wire sys_over_ovp,
    input wire sys_near_vin,
    input wire iin_over_limit,
    input wire rev_out_over_ov,
    input wire rev_out_short,
    // Register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    // Outputs
    output reg [15:0] reg_rdata,
    output reg input_good_n_pin,
    output reg int_n_pin,
    output reg switch_en,
    output reg reverse_buck_active,
    output reg term_disable,
    output reg timer_half_rate,
    output reg [2:0] thermal_regulation_limit
);

    localparam N = `CHGIRQ_NSRC;
    localparam NIN = 30;
    localparam ST_IDLE = 1'b0;
    localparam ST_PULSE = 1'b1;
    localparam [31:0] PCYC = PULSE_CYC;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire [NIN-1:0] raw_in;
    reg [NIN-1:0] s1_q;
    reg [NIN-1:0] s2_q;
    reg [NIN-1:0] s3_q;
    reg [NIN-1:0] in_q;
    assign raw_in = {vin_above_uvlo, vin_over_ov, vin_poor, src_detect_done,
                     source_type_status, icr_register_loop, current_limit_pin_over,
                     vreg_loop, tj_over_thermal_regulation_limit, tj_over_shut, tj_below_hys, wdog_expired,
                     charge_state, battery_temp_status, bat_over_ov, safety_tmr_expired,
                     sys_over_ovp, sys_near_vin, iin_over_limit, rev_out_over_ov,
                     rev_out_short, 3'b000};

    // A change counts only when stages two and three agree
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= {NIN{1'b0}};
            s2_q <= {NIN{1'b0}};
            s3_q <= {NIN{1'b0}};
            in_q <= {NIN{1'b0}};
        end
        else
        begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= (s2_q & s3_q) | (in_q & (s2_q | s3_q));
        end
    end

    wire f_uvlo = in_q[29];
    wire f_ov = in_q[28];
    wire f_poor = in_q[27];
    wire f_det = in_q[26];
    wire [2:0] f_srct = in_q[25:23];
    wire f_icr_reg = in_q[22];
    wire f_current_limit_pin = in_q[21];
    wire f_vreg = in_q[20];
    wire f_thermal_regulation_limit = in_q[19];
    wire f_thermal_shutdown = in_q[18];
    wire f_cool = in_q[17];
    wire f_wdog = in_q[16];
    wire [2:0] f_chg = in_q[15:13];
    wire [2:0] f_btemp = in_q[12:10];
    wire f_bovp = in_q[9];
    wire f_tmr = in_q[8];
    wire f_sovp = in_q[7];
    wire f_near = in_q[6];
    wire f_iin = in_q[5];
    wire f_rovp = in_q[4];
    wire f_rshort = in_q[3];

    // ------------------------------------------------------------
    // Control register and reverse enable
    // ------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg rev_en_q;
    reg boot_q;
    wire wr_ctrl = reg_wr && (reg_addr == `CHGIRQ_REG_CTRL);
    wire current_limit_pin_en = ctrl_q[`CHGIRQ_C_CURRENT_LIMIT_PIN_EN];
    wire thermal_shutdown_hot = f_thermal_shutdown && !f_cool;

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `CHGIRQ_CTRL_RST;
            rev_en_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata[7:0];
            // Fault clear wins over a host write in the same cycle
            if (rev_en_q && (f_rovp || f_rshort || thermal_shutdown_hot))
                rev_en_q <= 1'b0;
            else if (wr_ctrl)
                rev_en_q <= reg_wdata[`CHGIRQ_C_REV_EN];
        end
    end

    // ------------------------------------------------------------
    // Live status vector
    // ------------------------------------------------------------
    reg [2:0] srct_q;
    reg [2:0] chg_q;
    reg [2:0] btemp_q;
    reg rev_fault_q;
    reg good_q;
    wire good = f_uvlo && !f_ov && !f_poor && f_det;
    wire icr = f_icr_reg || (current_limit_pin_en && f_current_limit_pin);
    wire [N-1:0] stat;

    assign stat[`CHGIRQ_B_GOOD] = good;
    assign stat[`CHGIRQ_B_GONE] = !good;
    assign stat[`CHGIRQ_B_SRCT] = |(srct_q ^ f_srct);
    assign stat[`CHGIRQ_B_ICR] = icr;
    assign stat[`CHGIRQ_B_VR] = f_vreg;
    assign stat[`CHGIRQ_B_THERMAL_REGULATION_LIMIT] = f_thermal_regulation_limit;
    assign stat[`CHGIRQ_B_WDOG] = f_wdog || boot_q;
    assign stat[`CHGIRQ_B_CHG] = |(chg_q ^ f_chg);
    assign stat[`CHGIRQ_B_BTEMP] = |(btemp_q ^ f_btemp);
    assign stat[`CHGIRQ_B_OVP] = f_ov;
    assign stat[`CHGIRQ_B_THERMAL_SHUTDOWN] = thermal_shutdown_hot;
    assign stat[`CHGIRQ_B_BOVP] = f_bovp;
    assign stat[`CHGIRQ_B_TMR] = f_tmr;
    assign stat[`CHGIRQ_B_SHORT] = f_near && f_iin;
    assign stat[`CHGIRQ_B_REV] = rev_fault_q;

    // ------------------------------------------------------------
    // Flags, masks and edge detection
    // ------------------------------------------------------------
    reg [15:0] mask_q;
    reg pend_q;
    wire [N-1:0] evt_v;
    wire [N-1:0] flag_v;
    wire rd_flag = reg_rd && (reg_addr == `CHGIRQ_REG_FLAG);
    genvar j;

    // One cell per source keeps edge, flag and mask handling identical
    generate
        for (j = 0; j < N; j = j + 1)
        begin : g_src
            // Removed starts high so leaving reset is not seen as a removal
            chgirq_src_cell #(
                .STAT_RST(j == `CHGIRQ_B_GONE ? 1'b1 : 1'b0)
            ) chgirq_src_cell_inst (
                .core_clk(core_clk),
                .rstn(rstn),
                .stat_in(stat[j]),
                .flag_clr(rd_flag),
                .mask_bit(mask_q[j]),
                .evt(evt_v[j]),
                .flag_q(flag_v[j])
            );
        end
    endgenerate

    // Change-type sources are one-cycle; edge re-arms by tracking values
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mask_q <= `CHGIRQ_MASK_RST;
            srct_q <= 3'h0;
            chg_q <= 3'h0;
            btemp_q <= 3'h0;
            boot_q <= 1'b1;
            good_q <= 1'b0;
            rev_fault_q <= 1'b0;
        end
        else
        begin
            srct_q <= f_srct;
            chg_q <= f_chg;
            btemp_q <= f_btemp;
            boot_q <= 1'b0;
            good_q <= good;
            rev_fault_q <= rev_en_q && (f_rovp || f_rshort);
            if (reg_wr && (reg_addr == `CHGIRQ_REG_MASK))
                mask_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pulse generator
    // ------------------------------------------------------------
    reg st_q;
    reg [31:0] cnt_q;
    wire evt = |evt_v;
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 32'h00000000;
            pend_q <= 1'b0;
            int_n_pin <= 1'b1;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (evt || pend_q)
                    begin
                        st_q <= ST_PULSE;
                        cnt_q <= PCYC - 32'h00000001;
                        pend_q <= 1'b0;
                        int_n_pin <= 1'b0;
                    end
                end
                ST_PULSE:
                begin
                    // Events in a pulse queue one following pulse
                    if (evt)
                        pend_q <= 1'b1;
                    if (cnt_q == 32'h00000000)
                    begin
                        st_q <= ST_IDLE;
                        int_n_pin <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q - 32'h00000001;
                end
                default:
                begin
                    st_q <= ST_IDLE;
                    int_n_pin <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Protection outputs and read port
    // ------------------------------------------------------------
    wire stop = f_ov || f_poor || f_sovp || thermal_shutdown_hot || (f_near && f_iin);
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            input_good_n_pin <= 1'b1;
            switch_en <= 1'b0;
            reverse_buck_active <= 1'b0;
            term_disable <= 1'b0;
            timer_half_rate <= 1'b0;
            thermal_regulation_limit <= 3'h0;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            input_good_n_pin <= !good_q;
            switch_en <= !stop && !rev_en_q;
            reverse_buck_active <= rev_en_q && !f_rovp && !f_rshort && !thermal_shutdown_hot;
            term_disable <= f_thermal_regulation_limit;
            timer_half_rate <= f_thermal_regulation_limit || icr || f_vreg;
            thermal_regulation_limit <= ctrl_q[`CHGIRQ_C_THERMAL_REGULATION_LIMIT_MSB:`CHGIRQ_C_THERMAL_REGULATION_LIMIT_LSB];
            reg_rdata <= 16'h0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `CHGIRQ_REG_STAT: reg_rdata <= {1'b0, stat};
                    `CHGIRQ_REG_FLAG: reg_rdata <= {1'b0, flag_v};
                    `CHGIRQ_REG_MASK: reg_rdata <= mask_q;
                    `CHGIRQ_REG_CTRL: reg_rdata <= {8'h00, ctrl_q[7:2], rev_en_q, ctrl_q[0]};
                    `CHGIRQ_REG_SRCT: reg_rdata <= {7'h00, f_btemp, f_chg, f_srct};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule // chgirq_top

// ------------------------------------------------------------
// Interrupt source cell
// ------------------------------------------------------------
// One source: rising edge of its status, sticky flag, mask gate.
// Assumes the status is already synchronous to core_clk.
module chgirq_src_cell #(
    parameter [0:0] STAT_RST = 1'b0
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Source status and host controls
    input wire stat_in,
    input wire flag_clr,
    input wire mask_bit,
    // Results
    output wire evt,
    output reg flag_q
);

    reg stat_q;
    wire rise = stat_in && !stat_q;

    // Masking gates only the pulse; the flag still records the cause
    assign evt = rise && !mask_bit;

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_q <= STAT_RST;
            flag_q <= 1'b0;
        end
        else
        begin
            stat_q <= stat_in;
            // New edge wins over a read clear in the same cycle
            flag_q <= (flag_q && !flag_clr) || rise;
        end
    end

endmodule // chgirq_src_cell

// ==== hw/chgirq_defines.vh ====
// Constants for the charger status, interrupt and protection block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef CHGIRQ_DEFINES_VH
`define CHGIRQ_DEFINES_VH

`define CHGIRQ_CLK_MHZ 100
`define CHGIRQ_PULSE_US 256
`define CHGIRQ_PULSE_CYC (`CHGIRQ_PULSE_US * `CHGIRQ_CLK_MHZ)

// Register indices
`define CHGIRQ_REG_STAT 8'h00
`define CHGIRQ_REG_FLAG 8'h01
`define CHGIRQ_REG_MASK 8'h02
`define CHGIRQ_REG_CTRL 8'h03
`define CHGIRQ_REG_SRCT 8'h04

// Source bit positions in status, flag and mask words
`define CHGIRQ_B_GOOD 0
`define CHGIRQ_B_GONE 1
`define CHGIRQ_B_SRCT 2
`define CHGIRQ_B_ICR 3
`define CHGIRQ_B_VR 4
`define CHGIRQ_B_THERMAL_REGULATION_LIMIT 5
`define CHGIRQ_B_WDOG 6
`define CHGIRQ_B_CHG 7
`define CHGIRQ_B_BTEMP 8
`define CHGIRQ_B_OVP 9
`define CHGIRQ_B_THERMAL_SHUTDOWN 10
`define CHGIRQ_B_BOVP 11
`define CHGIRQ_B_TMR 12
`define CHGIRQ_B_SHORT 13
`define CHGIRQ_B_REV 14
`define CHGIRQ_NSRC 15

// Control register fields
`define CHGIRQ_C_CURRENT_LIMIT_PIN_EN 0
`define CHGIRQ_C_REV_EN 1
`define CHGIRQ_C_THERMAL_REGULATION_LIMIT_LSB 2
`define CHGIRQ_C_THERMAL_REGULATION_LIMIT_MSB 4
`define CHGIRQ_CTRL_RST 8'h01
`define CHGIRQ_MASK_RST 16'h0000

`endif

// ==== dv/chgirq_sva.sv ====
// Port checker for the charger status and interrupt block.
// Assumes one clock domain and PULSE_CYC equal to the bound instance.
`timescale 1ns/1ps
module chgirq_sva #(
    parameter PULSE_CYC = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Watched inputs
    input wire vin_above_uvlo,
    input wire vin_over_ov,
    input wire vin_poor,
    input wire src_detect_done,
    input wire tj_over_thermal_regulation_limit,
    input wire sys_over_ovp,
    input wire rev_out_over_ov,
    input wire rev_out_short,
    // Watched outputs
    input wire int_n_pin,
    input wire input_good_n_pin,
    input wire switch_en,
    input wire reverse_buck_active,
    input wire term_disable,
    input wire timer_half_rate
);
    // ----------------
    // Helpers
    // ----------------
    wire good_in = vin_above_uvlo && !vin_over_ov && !vin_poor && src_detect_done;
    reg [15:0] low_cnt_q;
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= int_n_pin ? 16'h0000 : low_cnt_q + 16'h0001;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Inputs pass a sync filter, so levels must hold 8 cycles first
    pulse_len_a: assert property ($rose(int_n_pin) |-> low_cnt_q == 16'(PULSE_CYC))
        else $error("interrupt pulse length wrong");
    pulse_gap_a: assert property (!int_n_pin |-> low_cnt_q < 16'(PULSE_CYC))
        else $error("interrupt pulses without a gap");
    good_on_a: assert property (good_in [*8] |-> !input_good_n_pin)
        else $error("input good pin not low");
    good_off_a: assert property (!good_in [*8] |-> input_good_n_pin)
        else $error("input good pin not high");
    ovp_stop_a: assert property (vin_over_ov [*8] |-> !switch_en)
        else $error("switching during input overvoltage");
    poor_stop_a: assert property (vin_poor [*8] |-> !switch_en)
        else $error("switching on a weak input");
    system_overvoltage_stop_a: assert property (sys_over_ovp [*8] |-> !switch_en)
        else $error("switching during system overvoltage");
    thermal_regulation_limit_effect_a: assert property (tj_over_thermal_regulation_limit [*8] |-> term_disable && timer_half_rate)
        else $error("thermal regulation effects missing");
    rev_fault_a: assert property ((rev_out_over_ov || rev_out_short) [*8] |-> !reverse_buck_active)
        else $error("reverse buck still active on fault");
endmodule // chgirq_sva

// ==== dv/chgirq_host.sv ====
// Host model: watches the interrupt pin, counts pulses, times the last one.
// Assumes the pin idles high and is sampled on the core clock.
`timescale 1ns/1ps
module chgirq_host (
    // Clock
    input wire core_clk,
    // Interrupt pin
    input wire int_n_pin,
    // Observations
    output int n_pulse = 0,
    output int last_width = 0
);
    int width = 0;
    always @(posedge core_clk)
    begin
        width <= int_n_pin ? 0 : width + 1;
        if (!int_n_pin && width == 0)
            n_pulse <= n_pulse + 1;
        if (int_n_pin && width != 0)
            last_width <= width;
    end
endmodule // chgirq_host

// ==== dv/chgirq_top_tb.sv ====
// Testbench for the charger status and interrupt block.
// Assumes the defines header on the include path and PULSE_CYC of 8.
`timescale 1ns/1ps
`include "chgirq_defines.vh"
module chgirq_top_tb;
    reg core_clk = 1'h0, rstn = 1'h0, vin_above_uvlo = 1'h0, vin_over_ov = 1'h0, vin_poor = 1'h0;
    reg src_detect_done = 1'h0, icr_register_loop = 1'h0, current_limit_pin_over = 1'h0, vreg_loop = 1'h0;
    reg tj_over_thermal_regulation_limit = 1'h0, tj_over_shut = 1'h0, tj_below_hys = 1'h1, wdog_expired = 1'h0, bat_over_ov = 1'h0;
    reg safety_tmr_expired = 1'h0, sys_over_ovp = 1'h0, sys_near_vin = 1'h0, iin_over_limit = 1'h0;
    reg rev_out_over_ov = 1'h0, rev_out_short = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    reg [2:0] source_type_status = 3'h0, charge_state = 3'h0, battery_temp_status = 3'h0;
    reg [7:0] reg_addr = 8'h00;
    reg [15:0] reg_wdata = 16'h0000, d;
    wire [15:0] reg_rdata;
    wire input_good_n_pin, int_n_pin, switch_en, reverse_buck_active, term_disable, timer_half_rate;
    wire [2:0] thermal_regulation_limit;
    int n_fail = 0, checks_done = 0, n_pulse, last_width, p, k, i, q;
    chgirq_top #(.PULSE_CYC(8)) chgirq_top_inst (.*);
    chgirq_host chgirq_host_inst (.*);
    initial forever #5 core_clk = ~core_clk;
    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input [7:0] a, input [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    // Bounded waits; running out is a mismatch
    task automatic wait_int(input bit lvl);
        for (i = 0; i < 60 && int_n_pin !== lvl; i++)
            @(posedge core_clk) #1;
        if (i == 60)
        begin
            chk("int_n_pin", {15'h0000, lvl}, {15'h0000, int_n_pin});
            end_of_test;
        end
    endtask
    task automatic settle;
        q = 0;
        for (i = 0; i < 300 && q < 12; i++)
            @(posedge core_clk) #1 q = int_n_pin ? q + 1 : 0;
        if (q < 12)
        begin
            chk("int_n_pin quiet", 16'h0001, 16'h0000);
            end_of_test;
        end
    endtask
    task automatic set_src(input int s, input bit v);
        @(posedge core_clk);
        case (s)
            2: source_type_status <= v ? 3'h5 : 3'h0;
            3: icr_register_loop <= v;
            4: vreg_loop <= v;
            5: tj_over_thermal_regulation_limit <= v;
            6: wdog_expired <= v;
            7: charge_state <= v ? 3'h3 : 3'h0;
            8: battery_temp_status <= v ? 3'h6 : 3'h0;
            9: vin_over_ov <= v;
            10: {tj_over_shut, tj_below_hys} <= {v, !v};
            11: bat_over_ov <= v;
            12: safety_tmr_expired <= v;
            13: {sys_near_vin, iin_over_limit, sys_over_ovp} <= {v, v, v};
            14: rev_out_over_ov <= v;
            default: rev_out_short <= v;
        endcase
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_boot;
        wait_int(1'b0);
        wait_int(1'b1);
        rd(`CHGIRQ_REG_FLAG);
        chk("ready flag", 16'h0040, d);
        rd(`CHGIRQ_REG_FLAG);
        chk("flag after read", 16'h0000, d);
        chk("pulse width", 16'h0008, 16'(last_width));
        rd(`CHGIRQ_REG_MASK);
        chk("mask reset", 16'h0000, d);
        rd(`CHGIRQ_REG_CTRL);
        chk("ctrl reset", 16'h0001, d);
        rd(8'h10);
        chk("unmapped", 16'h0000, d);
        $display("t_boot done");
    endtask
    task automatic t_good;
        @(posedge core_clk);
        vin_above_uvlo <= 1'h1;
        src_detect_done <= 1'h1;
        wait_int(1'b0);
        wait_int(1'b1);
        chk("good pin", 16'h0000, {15'h0000, input_good_n_pin});
        rd(`CHGIRQ_REG_STAT);
        chk("good stat", 16'h0001, d & 16'h0001);
        rd(`CHGIRQ_REG_FLAG);
        chk("good flag", 16'h0001, d & 16'h0001);
        rd(`CHGIRQ_REG_FLAG);
        chk("good flag again", 16'h0000, d & 16'h0001);
        @(posedge core_clk);
        vin_poor <= 1'h1;
        settle;
        chk("poor pin", 16'h0001, {15'h0000, input_good_n_pin});
        rd(`CHGIRQ_REG_FLAG);
        chk("removed flag", 16'h0002, d & 16'h0002);
        @(posedge core_clk);
        {vin_poor, vin_above_uvlo} <= 2'h0;
        settle;
        rd(`CHGIRQ_REG_FLAG);
        $display("t_good done");
    endtask
    // One pass per source from source type up, including both reverse faults with re-enable
    task automatic t_events;
        for (k = 2; k < 16; k++)
        begin
            if (k > 13)
                wr(`CHGIRQ_REG_CTRL, 16'h0017);
            rd(`CHGIRQ_REG_CTRL);
            chk("limit code", 16'h0005, {13'h0000, thermal_regulation_limit});
            chk("rev active", {15'h0000, k > 13}, {15'h0000, reverse_buck_active});
            p = n_pulse;
            set_src(k, 1'b1);
            wait_int(1'b0);
            wait_int(1'b1);
            rd(`CHGIRQ_REG_FLAG);
            chk("src flag", 16'h0001 << (k > 13 ? 14 : k), d & (16'h0001 << (k > 13 ? 14 : k)));
            chk("one pulse", 16'h0001, 16'(n_pulse - p));
            rd(`CHGIRQ_REG_CTRL);
            chk("rev enable", 16'h0000, d & 16'h0002);
            chk("switch en", {15'h0000, !(k == 9 || k == 10 || k == 13)}, {15'h0000, switch_en});
            set_src(k, 1'b0);
            settle;
            chk("switch resume", 16'h0001, {15'h0000, switch_en});
            rd(`CHGIRQ_REG_FLAG);
        end
        $display("t_events done");
    endtask
    task automatic t_mask;
        wr(`CHGIRQ_REG_MASK, 16'h0008);
        p = n_pulse;
        @(posedge core_clk);
        current_limit_pin_over <= 1'h1;
        settle;
        rd(`CHGIRQ_REG_FLAG);
        chk("masked flag", 16'h0008, d & 16'h0008);
        chk("masked pulses", 16'h0000, 16'(n_pulse - p));
        @(posedge core_clk);
        current_limit_pin_over <= 1'h0;
        wr(`CHGIRQ_REG_CTRL, 16'h0000);
        settle;
        rd(`CHGIRQ_REG_FLAG);
        @(posedge core_clk);
        current_limit_pin_over <= 1'h1;
        settle;
        rd(`CHGIRQ_REG_FLAG);
        chk("pin off flag", 16'h0000, d & 16'h0008);
        $display("t_mask done");
    endtask
    task automatic t_merge;
        p = n_pulse;
        set_src(11, 1'b1);
        wait_int(1'b0);
        set_src(12, 1'b1);
        settle;
        chk("merged pulses", 16'h0002, 16'(n_pulse - p));
        rd(`CHGIRQ_REG_FLAG);
        chk("merged flags", 16'h1800, d & 16'h1800);
        $display("t_merge done");
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'h1;
        t_boot;
        t_good;
        wr(`CHGIRQ_REG_CTRL, 16'h0015);
        t_events;
        t_mask;
        t_merge;
        end_of_test;
    end
endmodule // chgirq_top_tb
bind chgirq_top chgirq_sva #(.PULSE_CYC(PULSE_CYC)) chgirq_sva_inst (.*);
